// ---- host_ser_model.sv ----
// host side of the serial write port: frames of address byte then data byte
// assumes the bench calls write_reg; pins move 1 ns after clk_sys_i rises
module host_ser_model
(
  input  wire logic clk_sys_i,  // system clock
  output logic      cs_n_o,     // chip select, active low
  output logic      sclk_o,     // serial clock, idle low
  output logic      sdata_o     // serial data, msb first
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle pins at time zero
  initial
  begin
    cs_n_o  = 1'b1;
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
  end

  // ****************************************************************
  // one frame, three system cycles per half bit
  // ****************************************************************
  // sync written on demand
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    @(posedge clk_sys_i);
    #1 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (3) @(posedge clk_sys_i);
      #1 sclk_o = 1'b0;
      sdata_o = frame[i];
      repeat (3) @(posedge clk_sys_i);
      #1 sclk_o = 1'b1;
    end
    repeat (3) @(posedge clk_sys_i);
    #1 sclk_o = 1'b0;
    // released data line shows the inverse of the last bit
    sdata_o = ~frame[0];
    repeat (3) @(posedge clk_sys_i);
    #1 cs_n_o = 1'b1;
    // let the register and the outputs take the frame
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
endmodule

// ---- led_scan_core.sv ----
// multiplex scan, brightness and blink timing core of an led driver
// assumes synchronous pins, plane data held stable by the storage outside
//
// Summary of operation
// - address 07 bit 0 selects lamp test
// - address 03 bits 2..0 set last digit
// - blink off uses primary plane only
// - blink on alternates planes each phase
// - differing plane bits flash, equal bits steady
// - blink from divided multiplex clock, two speeds
// - slow 0.5 Hz, fast 1 Hz at 4 MHz
// - scan and blink share one multiplex clock
// - address 02 sets duty (k+1)/16, max 15/16
// - refresh is clock over 800 per digit
// - each digit slot lasts 800 clock ticks
// - fail-safe keeps effective clock above 75.5 kHz
// - fail-safe works for any clock source
// - sync bit clears dividers and digit sequence
// - sync clear happens at chip-select release
// - configuration bit 3 enables blinking
// - configuration bit 2 selects fast blink
// - configuration bit 4 requests timing clear
module led_scan_core
#(
  parameter int BLINK_SLOW_HALF = led_scan_pkg::BLINK_SLOW_HALF,  // ticks per slow phase
  parameter int BLINK_FAST_HALF = led_scan_pkg::BLINK_FAST_HALF   // ticks per fast phase
)
(
  input  wire logic        clk_sys_i,          // system clock
  input  wire logic        resetn_i,           // asynchronous reset, active low
  input  wire logic        cs_n_i,             // serial chip select, active low
  input  wire logic        sclk_i,             // serial clock
  input  wire logic        sdata_i,            // serial data
  input  wire logic        mux_clk_i,          // multiplex_clock_input level
  input  wire logic [63:0] primary_plane_i,    // digit bytes, digit 0 lowest
  input  wire logic [63:0] alternate_plane_i,  // digit bytes, digit 0 lowest
  output logic      [7:0]  digit_en_o,         // one-hot digit enable
  output logic      [7:0]  segment_o,          // segment drive, bit 7 is dp
  output logic             plane_alt_o,        // alternate plane in use
  output logic             failsafe_o          // fail-safe ticks in use
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [5:0]  STEP_LAST = 6'(led_scan_pkg::STEP_TICKS - 1);
  localparam logic [3:0]  SLOT_LAST = 4'(led_scan_pkg::DUTY_STEPS - 1);
  localparam logic [22:0] SLOW_LAST = 23'(BLINK_SLOW_HALF - 1);
  localparam logic [22:0] FAST_LAST = 23'(BLINK_FAST_HALF - 1);
  localparam int SETTLE_MIN = 1;  // output update latency
  localparam int SETTLE_MAX = 2;

  // ****************************************************************
  // front-end blocks
  // ****************************************************************
  scan_evt_if evt ();  // frames and ticks

  // serial register writes
  serial_frame_rx u_rx
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .cs_n_i    (cs_n_i),
    .sclk_i    (sclk_i),
    .sdata_i   (sdata_i),
    .evt       (evt.rx_src)
  );

  // effective multiplex ticks
  mux_tick_gen u_tick
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .mux_clk_i (mux_clk_i),
    .evt       (evt.tick_src)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [3:0]  duty_code_q;   // brightness code
  logic [2:0]  digit_lim_q;   // last scanned digit
  logic        lamp_test_q;   // lamp test selected
  logic        blink_en_q;    // blinking enabled
  logic        blink_fast_q;  // fast blink selected
  logic        sync_clr;      // timing chain clear request

  // write decode at chip-select release
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      duty_code_q  <= led_scan_pkg::RST_BRIGHTNESS;
      digit_lim_q  <= led_scan_pkg::RST_DIGIT_LIM;
      lamp_test_q  <= led_scan_pkg::RST_LAMP_TEST;
      blink_en_q   <= led_scan_pkg::RST_BLINK_EN;
      blink_fast_q <= led_scan_pkg::RST_BLINK_FAST;
    end
    else if (evt.frame_stb)
    begin
      unique case (evt.frame_addr)
        led_scan_pkg::ADDR_BRIGHTNESS:
          duty_code_q <= evt.frame_data[led_scan_pkg::DUTY_MSB:0];
        // three-bit digit limit, upper bits dropped
        led_scan_pkg::ADDR_DIGIT_LIM:
          digit_lim_q <= evt.frame_data[led_scan_pkg::LIM_MSB:0];
        led_scan_pkg::ADDR_LAMP_TEST:
          lamp_test_q <= evt.frame_data[led_scan_pkg::BIT_LAMP_TEST];
        led_scan_pkg::ADDR_CONFIG:
        begin
          blink_en_q   <= evt.frame_data[led_scan_pkg::BIT_BLINK_EN];
          blink_fast_q <= evt.frame_data[led_scan_pkg::BIT_BLINK_FAST];
        end
        // other addresses belong to other blocks
        default:
        begin
        end
      endcase
    end
  end

  // sync bit of a configuration write
  // acts at the frame strobe, i.e. chip-select release
  assign sync_clr = evt.frame_stb && (evt.frame_addr == led_scan_pkg::ADDR_CONFIG) &&
                    evt.frame_data[led_scan_pkg::BIT_BLINK_SYNC];

  // ****************************************************************
  // scan divider chain
  // ****************************************************************
  logic [5:0] pre_q;    // ticks within a duty step
  logic [3:0] step_q;   // duty step within a slot
  logic [2:0] digit_q;  // digit being scanned
  logic       step_end; // last tick of a step
  logic       slot_end; // last tick of a digit slot

  assign step_end = evt.mux_tick && (pre_q == STEP_LAST);
  assign slot_end = step_end && (step_q == SLOT_LAST);

  // scan timing counts multiplex ticks only
  // slot is step ticks times sixteen steps
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_q  <= 6'h00;
      step_q <= 4'h0;
    end
    else if (sync_clr)
    begin
      pre_q  <= 6'h00;
      step_q <= 4'h0;
    end
    else if (evt.mux_tick)
    begin
      pre_q <= (pre_q == STEP_LAST) ? 6'h00 : pre_q + 6'h01;
      if (step_end)
        step_q <= step_q + 4'h1;
    end
  end

  // ascending digit order with wrap at the limit
  // refresh is limit plus one slots
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      digit_q <= 3'h0;
    else if (sync_clr)
      digit_q <= 3'h0;
    else if (slot_end)
      digit_q <= (digit_q >= digit_lim_q) ? 3'h0 : digit_q + 3'h1;
  end

  // ****************************************************************
  // blink divider
  // ****************************************************************
  logic [22:0] blink_cnt_q;  // ticks within a blink phase
  logic        phase_q;      // blink phase, one is alternate
  logic [22:0] blink_last;   // phase length for the chosen rate

  // rate bit picks one of two divisions
  // half periods match 0.5 Hz and 1 Hz at 4 MHz
  assign blink_last = blink_fast_q ? FAST_LAST : SLOW_LAST;

  // phases run on without host action
  // sync clears the blink counter too
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      blink_cnt_q <= 23'h00_0000;
      phase_q     <= 1'b0;
    end
    else if (sync_clr)
    begin
      blink_cnt_q <= 23'h00_0000;
      phase_q     <= 1'b0;
    end
    else if (evt.mux_tick)
    begin
      if (blink_cnt_q >= blink_last)
      begin
        blink_cnt_q <= 23'h00_0000;
        phase_q     <= !phase_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 23'h00_0001;
    end
  end

  // ****************************************************************
  // segment and digit outputs
  // ****************************************************************
  logic [3:0] duty_eff;   // capped duty code
  logic       seg_on;     // inside the lit part of the slot
  logic       use_alt;    // alternate plane selected
  logic [7:0] prim_byte;  // primary byte of current digit
  logic [7:0] alt_byte;   // alternate byte of current digit
  logic [7:0] seg_d;      // next segment drive
  logic [7:0] dig_d;      // next digit enable

  // code 15 gives the same duty as 14
  assign duty_eff  = (duty_code_q > led_scan_pkg::DUTY_CAP) ? led_scan_pkg::DUTY_CAP
                                                            : duty_code_q;
  assign seg_on    = (step_q <= duty_eff);
  // primary only while blink is off
  assign use_alt   = blink_en_q && phase_q;
  assign prim_byte = primary_plane_i[digit_q*8 +: 8];
  assign alt_byte  = alternate_plane_i[digit_q*8 +: 8];

  // digit enable decode, one bit per digit
  genvar gi;
  generate
    for (gi = 0; gi < led_scan_pkg::NUM_DIGITS; gi++)
    begin : g_dig
      assign dig_d[gi] = (digit_q == 3'(gi));
    end
  endgenerate

  // each phase shows its own plane bit
  // lamp test forces all segments in the lit steps, data untouched
  always_comb
  begin
    if (!seg_on)
      seg_d = 8'h00;
    else if (lamp_test_q)
      seg_d = 8'hFF;
    else if (use_alt)
      seg_d = alt_byte;
    else
      seg_d = prim_byte;
  end

  // registered outputs
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      digit_en_o  <= 8'h00;
      segment_o   <= 8'h00;
      plane_alt_o <= 1'b0;
      failsafe_o  <= 1'b0;
    end
    else
    begin
      digit_en_o  <= dig_d;
      segment_o   <= seg_d;
      plane_alt_o <= use_alt;
      failsafe_o  <= evt.fs_active;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // lamp test follows bit 0 only
  a_lamp_test_write: assert property (
    evt.frame_stb && evt.frame_addr == led_scan_pkg::ADDR_LAMP_TEST
    |=> lamp_test_q == $past(evt.frame_data[0]))
    else $error("lamp test bit not taken");

  // limit takes the low three bits
  a_digit_limit_write: assert property (
    evt.frame_stb && evt.frame_addr == led_scan_pkg::ADDR_DIGIT_LIM
    |=> digit_lim_q == $past(evt.frame_data[2:0]))
    else $error("digit limit not taken");

  // blink off never shows the alternate plane
  a_primary_only: assert property (
    !blink_en_q |=> !plane_alt_o)
    else $error("alternate plane used with blink off");

  // phase flips at end of a blink phase
  a_phase_toggle: assert property (
    evt.mux_tick && !sync_clr && blink_cnt_q >= blink_last
    |=> phase_q != $past(phase_q))
    else $error("blink phase did not flip");

  a_plane_select: assert property (
    seg_on && !lamp_test_q && use_alt |=> segment_o == $past(alt_byte))
    else $error("alternate byte not shown");

  // blanking in the last step of every slot
  a_blank_step: assert property (
    step_q == SLOT_LAST |-> ##[SETTLE_MIN:SETTLE_MAX] segment_o == 8'h00)
    else $error("no blanking in last step");

  // wrap to digit zero past the limit
  a_digit_wrap: assert property (
    slot_end && !sync_clr && digit_q >= digit_lim_q |=> digit_q == 3'h0)
    else $error("digit did not wrap");

  // digit advances only at slot end
  a_digit_hold: assert property (
    !slot_end && !sync_clr |=> $stable(digit_q))
    else $error("digit moved inside a slot");

  // sync clears the whole timing chain
  a_sync_clear: assert property (
    sync_clr |=> pre_q == 6'h00 && step_q == 4'h0 && digit_q == 3'h0 &&
                 blink_cnt_q == 23'h00_0000)
    else $error("sync did not clear timing");

  // lamp test lights all segments when lit
  a_lamp_all_on: assert property (
    lamp_test_q && seg_on |=> segment_o == 8'hFF)
    else $error("lamp test not all on");

  c_blink_flip: cover property (blink_en_q && $changed(phase_q));
  c_sync_write: cover property (sync_clr);
  c_digit_wrap: cover property (slot_end && digit_q == digit_lim_q);
  c_lamp_test:  cover property (lamp_test_q && segment_o == 8'hFF);
endmodule

// ---- led_scan_pkg.sv ----
// constants shared by the scan, blink and serial front-end blocks
// assumes a single 125 MHz system clock and a 4 MHz nominal multiplex clock
package led_scan_pkg;

  // ****************************************************************
  // register addresses and field positions
  // ****************************************************************
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h02;  // brightness_duty
  localparam logic [7:0] ADDR_DIGIT_LIM  = 8'h03;  // digit_count_limit
  localparam logic [7:0] ADDR_CONFIG     = 8'h04;  // configuration
  localparam logic [7:0] ADDR_LAMP_TEST  = 8'h07;  // lamp_test_control

  localparam int BIT_LAMP_TEST  = 0;  // lamp test select
  localparam int BIT_BLINK_FAST = 2;  // blink rate, one is fast
  localparam int BIT_BLINK_EN   = 3;  // blink enable
  localparam int BIT_BLINK_SYNC = 4;  // clear timing chain at frame end
  localparam int LIM_MSB        = 2;  // digit limit field top bit
  localparam int DUTY_MSB       = 3;  // brightness field top bit

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [3:0] RST_BRIGHTNESS = 4'h0;
  localparam logic [2:0] RST_DIGIT_LIM  = 3'h7;
  localparam logic       RST_LAMP_TEST  = 1'b0;
  localparam logic       RST_BLINK_EN   = 1'b0;
  localparam logic       RST_BLINK_FAST = 1'b0;

  // ****************************************************************
  // frame and timing figures
  // ****************************************************************
  localparam int FRAME_BITS    = 16;           // address byte then data byte
  localparam int CLK_HZ        = 125_000_000;  // system clock rate
  localparam int MUX_REF_HZ    = 4_000_000;    // nominal multiplex clock
  localparam int SLOT_NS       = 200_000;      // digit slot at nominal rate
  localparam int SLOT_TICKS    = (SLOT_NS * (MUX_REF_HZ / 1_000_000)) / 1000;
  localparam int DUTY_STEPS    = 16;           // brightness steps per slot
  localparam int STEP_TICKS    = SLOT_TICKS / DUTY_STEPS;
  localparam logic [3:0] DUTY_CAP = 4'hE;      // code 15 behaves as 14
  localparam int BLINK_SLOW_MHZ = 500;         // slow blink, millihertz
  localparam int BLINK_FAST_MHZ = 1000;        // fast blink, millihertz
  localparam int BLINK_SLOW_HALF = (MUX_REF_HZ / (2 * BLINK_SLOW_MHZ)) * 1000;
  localparam int BLINK_FAST_HALF = (MUX_REF_HZ / (2 * BLINK_FAST_MHZ)) * 1000;
  localparam int FS_MIN_DHZ    = 755_000;      // fail-safe floor, tenths of Hz
  localparam int FS_CYCLES     = (CLK_HZ * 10) / FS_MIN_DHZ;  // rounded down
  localparam int NUM_DIGITS    = 8;

endpackage

// ---- mux_tick_gen.sv ----
// multiplex clock edge detector with a fail-safe tick inserter
// assumes the multiplex clock pin is synchronous to clk_sys_i
module mux_tick_gen
(
  input  wire logic    clk_sys_i,
  input  wire logic    resetn_i,
  input  wire logic    mux_clk_i,
  scan_evt_if.tick_src evt
);
  localparam logic [11:0] FS_LAST = 12'(led_scan_pkg::FS_CYCLES - 1);

  logic        mux_q;  // previous multiplex clock level
  logic [11:0] gap_q;  // system cycles since last tick

  // same watchdog for any clock source
  // insert a tick when the clock stalls
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mux_q        <= 1'b0;
      gap_q        <= 12'h000;
      evt.mux_tick <= 1'b0;
      evt.fs_active <= 1'b0;
    end
    else
    begin
      mux_q <= mux_clk_i;
      if (mux_clk_i && !mux_q)
      begin
        gap_q         <= 12'h000;
        evt.mux_tick  <= 1'b1;
        evt.fs_active <= 1'b0;
      end
      else if (gap_q == FS_LAST)
      begin
        gap_q         <= 12'h000;
        evt.mux_tick  <= 1'b1;
        evt.fs_active <= 1'b1;
      end
      else
      begin
        gap_q        <= gap_q + 12'h001;
        evt.mux_tick <= 1'b0;
      end
    end
  end

  // no gap longer than the fail-safe period
  a_failsafe_gap: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gap_q == FS_LAST |=> evt.mux_tick)
    else $error("fail-safe tick missing");

  c_failsafe_tick: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    evt.mux_tick && evt.fs_active);
endmodule

// ---- scan_evt_if.sv ----
// carrier for decoded frames and multiplex ticks between the scan blocks
// assumes all signals are synchronous to the system clock
interface scan_evt_if;
  logic       frame_stb;   // one-cycle pulse at chip-select release
  logic [7:0] frame_addr;  // register address of the frame
  logic [7:0] frame_data;  // register data of the frame
  logic       mux_tick;    // one pulse per effective multiplex clock edge
  logic       fs_active;   // last tick was inserted by the fail-safe

  modport rx_src   (output frame_stb, frame_addr, frame_data);
  modport tick_src (output mux_tick, fs_active);
  modport core     (input frame_stb, frame_addr, frame_data, mux_tick, fs_active);
endinterface

// ---- serial_frame_rx.sv ----
// serial write port: shifts address and data bytes, strobes at cs release
// assumes cs, sclk and data pins are already synchronous to clk_sys_i
module serial_frame_rx
(
  input  wire logic  clk_sys_i,
  input  wire logic  resetn_i,
  input  wire logic  cs_n_i,
  input  wire logic  sclk_i,
  input  wire logic  sdata_i,
  scan_evt_if.rx_src evt
);
  logic [15:0] shift_q;  // received bits, msb first
  logic [4:0]  count_q;  // bits taken in this frame
  logic        sclk_q;   // previous serial clock level
  logic        cs_n_q;   // previous chip-select level

  // sample data on each serial clock rising edge while selected
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_i;
      cs_n_q <= cs_n_i;
      if (cs_n_i)
        count_q <= 5'h00;
      else if (sclk_i && !sclk_q)
      begin
        shift_q <= {shift_q[14:0], sdata_i};
        if (count_q != 5'h1F)
          count_q <= count_q + 5'h01;
      end
    end
  end

  // frame strobe on release, only for exactly one full frame
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      evt.frame_stb <= 1'b0;
    else
      evt.frame_stb <= cs_n_i && !cs_n_q &&
                       (count_q == 5'(led_scan_pkg::FRAME_BITS));
  end

  assign evt.frame_addr = shift_q[15:8];
  assign evt.frame_data = shift_q[7:0];
endmodule

// ---- tb_top.sv ----
// self-checking bench for the led scan core: scan, duty, blink, sync, lamp test
// assumes host_ser_model drives the serial pins; the bench makes the mux clock
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK_CYC = 2;  // system cycles per mux tick
  localparam int SLOT_CYC = led_scan_pkg::SLOT_TICKS * TICK_CYC;
  localparam int STEP_CYC = led_scan_pkg::STEP_TICKS * TICK_CYC;
  localparam int FS       = led_scan_pkg::FS_CYCLES;
  localparam int HALF_TAB [2] = '{20, 40};  // ticks per fast, slow phase
  localparam logic [7:0] RATE_TAB [2] = '{8'h0C, 8'h08};
  localparam logic [7:0] LIM_TAB  [3] = '{8'hFA, 8'hF4, 8'h07};
  localparam int         ND_TAB   [3] = '{3, 5, 8};
  localparam logic [7:0] DUTY_TAB [4] = '{8'hA0, 8'h07, 8'h5E, 8'hFF};
  localparam logic [7:0] LAMP_TAB [3] = '{8'hFE, 8'h01, 8'h00};
  logic       clk_sys_i = 1'b0;  // system clock
  logic       resetn_i  = 1'b0;  // reset, active low
  logic       mux_clk   = 1'b0;  // multiplex clock level
  logic       mux_run   = 1'b1;  // multiplex clock running
  logic [7:0] pb        = 8'h01; // primary byte of every digit
  logic [7:0] ab        = 8'hFE; // alternate byte of every digit
  logic       cs_n;              // chip select, active low
  logic       sclk;              // serial clock
  logic       sdata;             // serial data
  logic [7:0] digit_en;          // scanned digit
  logic [7:0] segment;           // segment drive
  logic       plane_alt;         // alternate plane shown
  logic       failsafe;          // fail-safe ticks in use
  logic [7:0] dig_prev;          // last digit enable seen
  logic [7:0] exp_q [$];         // expected digit sequence
  int         n_errors   = 0;
  int         n_compared = 0;
  int         cyc        = 0;    // run length so far
  int         slot_cyc   = 0;    // cycles since last digit change

  host_ser_model u_host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdata_o(sdata));

  led_scan_core #(.BLINK_SLOW_HALF(HALF_TAB[1]), .BLINK_FAST_HALF(HALF_TAB[0])) DUT
  (
    .clk_sys_i         (clk_sys_i),
    .resetn_i          (resetn_i),
    .cs_n_i            (cs_n),
    .sclk_i            (sclk),
    .sdata_i           (sdata),
    .mux_clk_i         (mux_clk),
    .primary_plane_i   ({8{pb}}),
    .alternate_plane_i ({8{ab}}),
    .digit_en_o        (digit_en),
    .segment_o         (segment),
    .plane_alt_o       (plane_alt),
    .failsafe_o        (failsafe)
  );

  // system clock, 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;

  // one multiplex clock for scan and blink
  // pin range scaled up here only to keep runs short
  always @(posedge clk_sys_i)
    if (mux_run)
      mux_clk <= #1 ~mux_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // monitor: takes the oldest expected digit at each change; run limit
  always @(posedge clk_sys_i)
  begin
    cyc++;
    slot_cyc++;
    if (digit_en !== dig_prev)
    begin
      slot_cyc = 0;
      dig_prev = digit_en;
      if (exp_q.size() > 0)
        check(16'(digit_en), 16'(exp_q.pop_front()));
    end
    if (cyc == 95000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic drain();
    for (int c = 0; c < 30000 && exp_q.size() > 0; c++)
      @(posedge clk_sys_i);
    check(16'(exp_q.size()), 16'h0000);
    exp_q.delete();
  endtask

  task automatic wait_change(output int n);
    logic [7:0] d;
    d = digit_en;
    for (n = 1; n < 4 * SLOT_CYC; n++)
    begin
      @(posedge clk_sys_i);
      if (digit_en !== d)
        break;
    end
  endtask

  task automatic wait_alt(input logic v, output int n);
    for (n = 0; n < 1000 && plane_alt !== v; n++)
      @(posedge clk_sys_i);
  endtask

  // lit cycles of the primary byte in one slot, and alternate cycles seen
  task automatic lit_count(output int lit, output int alt);
    logic [7:0] d;
    d   = digit_en;
    lit = 0;
    alt = 0;
    for (int c = 0; c < 2 * SLOT_CYC && digit_en === d; c++)
    begin
      lit += int'(segment === pb);
      alt += int'(plane_alt !== 1'b0);
      @(posedge clk_sys_i);
    end
  endtask

  // main sequence
  initial
  begin
    int n;
    int tot;
    int k;
    void'($urandom(57));
    pb = (8'($urandom) & 8'h7E) | 8'h01;
    ab = ~pb;
    repeat (10) @(posedge clk_sys_i);
    check(16'(digit_en), 16'h0000);  // dark in reset
    #1 resetn_i = 1'b1;
    for (int i = 0; i < 9; i++)
      exp_q.push_back(8'h01 << (i % 8));
    drain();
    foreach (LIM_TAB[i])
    begin
      u_host.write_reg(led_scan_pkg::ADDR_DIGIT_LIM, LIM_TAB[i]);
      u_host.write_reg(led_scan_pkg::ADDR_CONFIG, 8'h10);
      check(16'(digit_en), 16'h0001);
      for (int j = 1; j <= ND_TAB[i] + 1; j++)
        exp_q.push_back(8'h01 << (j % ND_TAB[i]));
      tot = 0;
      for (int j = 0; j <= ND_TAB[i]; j++)
      begin
        wait_change(n);
        tot += (j > 0) ? n : 0;
      end
      check(16'(n), 16'(SLOT_CYC));
      check(16'(tot), 16'(ND_TAB[i] * SLOT_CYC));
      drain();
    end
    for (int i = 0; i < 5; i++)
    begin
      k = (i < 4) ? int'(DUTY_TAB[i]) : int'(8'($urandom));
      u_host.write_reg(led_scan_pkg::ADDR_BRIGHTNESS, 8'(k));
      u_host.write_reg(led_scan_pkg::ADDR_CONFIG, 8'h10);
      wait_change(n);
      lit_count(n, tot);
      check(16'(n), 16'(((k % 16 == 15) ? 15 : k % 16 + 1) * STEP_CYC));
      check(16'(tot), 16'h0000);
    end
    foreach (LAMP_TAB[i])
    begin
      u_host.write_reg(led_scan_pkg::ADDR_LAMP_TEST, LAMP_TAB[i]);
      wait_change(n);
      repeat (4) @(posedge clk_sys_i);
      check(16'(segment), 16'(LAMP_TAB[i][0] ? 8'hFF : pb));
    end
    // maximum duty, 15/16, so the plane check below sees a lit segment
    u_host.write_reg(led_scan_pkg::ADDR_BRIGHTNESS, 8'h0E);
    foreach (RATE_TAB[i])
    begin
      u_host.write_reg(led_scan_pkg::ADDR_CONFIG, RATE_TAB[i] | 8'h10);
      wait_alt(1'b1, n);
      repeat (3) @(posedge clk_sys_i);
      if (slot_cyc > 4 && slot_cyc < SLOT_CYC - STEP_CYC - 8)
        check(16'(segment), 16'(ab));
      wait_alt(1'b0, n);
      check(16'(n + 3), 16'(HALF_TAB[i] * TICK_CYC));
      wait_alt(1'b1, n);
      check(16'(n), 16'(HALF_TAB[i] * TICK_CYC));
    end
    @(posedge clk_sys_i);
    #1 mux_run = 1'b0;
    for (n = 0; n < 3000 && failsafe !== 1'b1; n++)
      @(posedge clk_sys_i);
    check(16'(n >= FS - 4 && n <= FS + 8), 16'h0001);
    #1 mux_run = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    check(16'(failsafe), 16'h0000);
    summarize();
  end
endmodule
